// ---- hdl/fbc_cmd_fsm.sv ----
// Command interpreter: standard unlock sequences, unlock bypass, chip erase, CFI
// and accelerated programming. Assumes synchronous bus pins and a 100 MHz clock.
`timescale 1ns/1ps
`include "fbc_regs.svh"
module fbc_cmd_fsm
  import fbc_pkg::*;
#(
  parameter int NUM_SECTORS = 8,
  parameter int PROG_CYCLES = `FBC_PROG_CYCLES,
  parameter int SECTOR_CYCLES = `FBC_SECTOR_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Flash write bus and status read strobe
  input wire logic chip_sel_n,
  input wire logic write_n,
  input wire logic [11:0] addr,
  input wire logic [31:0] data,
  input wire logic read_strobe,
  // Supplies and protection
  input wire logic high_voltage_level,
  input wire logic sector_protect_lock_bit,
  input wire logic secured_sector_en,
  input wire logic [NUM_SECTORS-1:0] sector_protected,
  // Status
  output logic ready_busy_n,
  output logic data_poll_bit,
  output logic toggle_bit,
  output logic bypass_mode,
  output logic cfi_mode,
  output logic erase_suspended,
  // Array operation requests
  output logic prog_we,
  output logic [11:0] prog_addr,
  output logic [31:0] prog_data,
  output logic prog_unprotected,
  output logic [NUM_SECTORS-1:0] erase_zero_we,
  output logic [NUM_SECTORS-1:0] erase_we
);
  localparam int CW = $clog2(PROG_CYCLES + SECTOR_CYCLES + 2);
  localparam int SW = $clog2(NUM_SECTORS + 1);

  logic wr_valid;
  fbc_write_t wr;
  fbc_state_t state_q;
  fbc_state_t base_q;
  fbc_op_t op_q;
  logic [CW-1:0] cnt_q;
  logic erase_phase_q;
  logic [NUM_SECTORS-1:0] erase_targets_q;
  logic [SW-1:0] sec_q;
  logic bypass_erase_q;
  logic poll_bit_q;
  logic done;
  logic [7:0] cmd;
  logic is_unl1;
  logic is_unl2;
  logic accel_ok;
  logic prog_start;
  logic erase_start;

  fbc_strobe_capture u_cap (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .chip_sel_n(chip_sel_n),
    .write_n(write_n),
    .addr(addr),
    .data(data),
    .wr_valid(wr_valid),
    .wr(wr)
  );

  assign cmd = wr.data[7:0];
  assign is_unl1 = wr.addr == `FBC_UNLOCK1_ADDR && cmd == `FBC_UNLOCK1_DATA;
  assign is_unl2 = wr.addr == `FBC_UNLOCK2_ADDR && cmd == `FBC_UNLOCK2_DATA;
  // Two-cycle accelerated program only with high voltage, no secured sector
  assign accel_ok = high_voltage_level && !secured_sector_en;
  assign done = op_q != FBC_OP_NONE && cnt_q == '0 && !erase_suspended
    && (op_q == FBC_OP_PROG || (erase_phase_q && sec_q == SW'(NUM_SECTORS)));

  // Command decode; hardware reset returns straight to read
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= FBC_READ;
      base_q <= FBC_READ;
      bypass_erase_q <= 1'b0;
    end else if (state_q == FBC_BUSY) begin
      // Only suspend and resume are looked at while busy; everything else dropped
      if (done) begin
        state_q <= base_q;
      end
    end else if (wr_valid) begin
      state_q <= base_q;
      case (state_q)
        FBC_READ: begin
          if (is_unl1) begin
            state_q <= FBC_UNL1;
          end
        end
        FBC_UNL1: begin
          if (is_unl2) begin
            state_q <= FBC_UNL2;
          end
        end
        FBC_UNL2: begin
          if (cmd == `FBC_CMD_BYPASS && !secured_sector_en) begin
            state_q <= FBC_BP_IDLE;
            base_q <= FBC_BP_IDLE;
          end else if (cmd == `FBC_CMD_ERASE_SETUP) begin
            state_q <= FBC_SETUP;
          end else if (cmd == `FBC_CMD_PROGRAM) begin
            state_q <= FBC_PROG_ADDR;
          end
        end
        FBC_SETUP: begin
          if (is_unl1) begin
            state_q <= FBC_UNL3;
          end
        end
        FBC_UNL3: begin
          if (is_unl2) begin
            state_q <= FBC_UNL4;
          end
        end
        FBC_UNL4: begin
          if (cmd == `FBC_CMD_CHIP_ERASE) begin
            state_q <= FBC_BUSY;
            bypass_erase_q <= 1'b0;
          end
        end
        FBC_PROG_ADDR: begin
          state_q <= FBC_BUSY;
        end
        FBC_BP_IDLE: begin
          // Unrelated writes simply leave us here
          if (cmd == `FBC_CMD_PROGRAM && (!secured_sector_en || accel_ok)) begin
            state_q <= FBC_BP_PROG;
          end else if (cmd == `FBC_CMD_ERASE_SETUP) begin
            state_q <= FBC_BP_ERASE;
          end else if (cmd == `FBC_CMD_EXIT1) begin
            state_q <= FBC_BP_EXIT;
          end else if (cmd == `FBC_CMD_CFI && wr.addr == `FBC_CFI_ADDR) begin
            state_q <= FBC_CFI;
          end
        end
        FBC_BP_PROG: begin
          state_q <= FBC_BUSY;
        end
        FBC_BP_ERASE: begin
          if (cmd == `FBC_CMD_CHIP_ERASE) begin
            state_q <= FBC_BUSY;
            bypass_erase_q <= 1'b1;
          end
        end
        FBC_BP_EXIT: begin
          if (cmd == `FBC_CMD_EXIT2) begin
            state_q <= FBC_READ;
            base_q <= FBC_READ;
          end
        end
        FBC_CFI: begin
          if (cmd != `FBC_CMD_RESET) begin
            state_q <= FBC_CFI;
          end
        end
        default: begin
          state_q <= FBC_READ;
          base_q <= FBC_READ;
        end
      endcase
    end
  end

  // Operation launch, progress and suspend
  assign prog_start = wr_valid && (state_q == FBC_PROG_ADDR || state_q == FBC_BP_PROG);
  assign erase_start = wr_valid && cmd == `FBC_CMD_CHIP_ERASE
    && (state_q == FBC_UNL4 || state_q == FBC_BP_ERASE);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_q <= FBC_OP_NONE;
      cnt_q <= '0;
      erase_phase_q <= 1'b0;
      erase_targets_q <= '0;
      sec_q <= '0;
      poll_bit_q <= 1'b0;
    end else if (prog_start) begin
      op_q <= FBC_OP_PROG;
      cnt_q <= CW'(PROG_CYCLES);
      poll_bit_q <= wr.data[`FBC_POLL_BIT];
    end else if (erase_start) begin
      op_q <= FBC_OP_ERASE;
      cnt_q <= CW'(SECTOR_CYCLES);
      erase_phase_q <= 1'b0;
      sec_q <= '0;
      erase_targets_q <= ~sector_protected;
      // Inverted on the way out, so the poll bit reads 0 while erasing
      poll_bit_q <= 1'b1;
    end else if (op_q != FBC_OP_NONE) begin
      if (done) begin
        op_q <= FBC_OP_NONE;
        erase_phase_q <= 1'b0;
      end else if (!erase_suspended) begin
        if (cnt_q != '0) begin
          cnt_q <= cnt_q - CW'(1);
        end else if (!erase_phase_q) begin
          // Zero-fill pass done, electrical erase next
          erase_phase_q <= 1'b1;
          cnt_q <= CW'(SECTOR_CYCLES);
        end else begin
          sec_q <= sec_q + SW'(1);
          cnt_q <= CW'(SECTOR_CYCLES);
        end
      end
    end
  end

  // Suspend only for a standard chip erase; bypass erase has none
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      erase_suspended <= 1'b0;
    end else if (op_q != FBC_OP_ERASE) begin
      erase_suspended <= 1'b0;
    end else if (wr_valid && !bypass_erase_q) begin
      if (cmd == `FBC_CMD_SUSPEND) begin
        erase_suspended <= 1'b1;
      end else if (cmd == `FBC_CMD_RESUME) begin
        erase_suspended <= 1'b0;
      end
    end
  end

  // Program request; address and data held until the next request
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_we <= 1'b0;
      prog_addr <= 12'h000;
      prog_data <= 32'h0000_0000;
      prog_unprotected <= 1'b0;
    end else begin
      prog_we <= prog_start;
      if (prog_start) begin
        prog_addr <= wr.addr;
        prog_data <= wr.data;
        // Accelerated program skips protection unless the lock bit is set
        prog_unprotected <= state_q == FBC_BP_PROG && accel_ok
          && !sector_protect_lock_bit;
      end
    end
  end

  // Per-sector erase pulses, only for unprotected targets
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SECTORS; gi++) begin : g_sec
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          erase_zero_we[gi] <= 1'b0;
          erase_we[gi] <= 1'b0;
        end else begin
          erase_zero_we[gi] <= op_q == FBC_OP_ERASE && !erase_phase_q
            && erase_targets_q[gi] && cnt_q == CW'(SECTOR_CYCLES);
          erase_we[gi] <= op_q == FBC_OP_ERASE && erase_phase_q && !erase_suspended
            && erase_targets_q[gi] && cnt_q == '0
            && sec_q == SW'(gi);
        end
      end
    end
  endgenerate

  // Busy and poll status; released in the cycle the operation ends
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_busy_n <= 1'b1;
      data_poll_bit <= 1'b1;
    end else begin
      ready_busy_n <= op_q == FBC_OP_NONE || done;
      data_poll_bit <= (op_q == FBC_OP_NONE || done) ? 1'b1 : ~poll_bit_q;
    end
  end

  // Toggle advances per status read while busy; frozen in suspend
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      toggle_bit <= 1'b0;
    end else if (op_q != FBC_OP_NONE && !erase_suspended && read_strobe) begin
      toggle_bit <= ~toggle_bit;
    end
  end

  // Mode flags
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bypass_mode <= 1'b0;
      cfi_mode <= 1'b0;
    end else begin
      bypass_mode <= base_q == FBC_BP_IDLE;
      cfi_mode <= state_q == FBC_CFI;
    end
  end
endmodule

// ---- hdl/fbc_regs.svh ----
// Constants of the flash bypass/erase command interpreter: command codes, unlock
// addresses, field positions and timing counts. Assumes a 100 MHz system clock.
// Function
// - Accelerated program needs high-voltage supply first
// - Accelerated program only in bypass, idle
// - Accelerated program ignores protection unless lock set
// - Accelerated program refused with secured sector on
// - Two unlocks then 20h enter bypass
// - Bypass program: A0h then address/data, repeatable
// - Bypass mode ignores unrelated command writes
// - 90h then 00h leaves bypass mode
// - Bypass chip erase: 80h then 10h
// - Bypass chip erase takes no suspend/resume
// - Bypass entry ignored with secured sector on
// - Bypass program ignored with secured sector on
// - CFI query available inside bypass mode
// - Bypass reset restores standard read state
// - Standard chip erase is six write cycles
// - Chip erase skips protected sectors
// - Erase preprograms zeros, then erases electrically
// - Erase starts at final strobe rising edge
// - Erase reports data poll, toggle, ready/busy
// - During erase only suspend accepted
// - After operation return to array read
// - Address at later fall, data at earlier rise
`ifndef FBC_REGS_SVH
`define FBC_REGS_SVH

`define FBC_UNLOCK1_ADDR 12'h555
`define FBC_UNLOCK2_ADDR 12'h2AA
`define FBC_UNLOCK1_DATA 8'hAA
`define FBC_UNLOCK2_DATA 8'h55
`define FBC_CMD_BYPASS 8'h20
`define FBC_CMD_PROGRAM 8'hA0
`define FBC_CMD_ERASE_SETUP 8'h80
`define FBC_CMD_CHIP_ERASE 8'h10
`define FBC_CMD_EXIT1 8'h90
`define FBC_CMD_EXIT2 8'h00
`define FBC_CMD_CFI 8'h98
`define FBC_CMD_RESET 8'hF0
`define FBC_CMD_SUSPEND 8'hB0
`define FBC_CMD_RESUME 8'h30
`define FBC_CFI_ADDR 12'h055
`define FBC_POLL_BIT 7
`define FBC_TOGGLE_BIT 6
`define FBC_PROG_TIME_NS 10000
`define FBC_SECTOR_TIME_NS 20000
`define FBC_CLK_PERIOD_NS 10
`define FBC_PROG_CYCLES (`FBC_PROG_TIME_NS / `FBC_CLK_PERIOD_NS)
`define FBC_SECTOR_CYCLES (`FBC_SECTOR_TIME_NS / `FBC_CLK_PERIOD_NS)

`endif

// ---- hdl/fbc_pkg.sv ----
// Types of the flash bypass/erase command interpreter.
// Shared by the interpreter and its strobe capture module.
package fbc_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
  } fbc_write_t;

  typedef enum logic [3:0] {
    FBC_READ = 4'h0,
    FBC_UNL1 = 4'h1,
    FBC_UNL2 = 4'h3,
    FBC_SETUP = 4'h2,
    FBC_UNL3 = 4'h6,
    FBC_UNL4 = 4'h7,
    FBC_PROG_ADDR = 4'h5,
    FBC_BUSY = 4'h4,
    FBC_BP_IDLE = 4'hC,
    FBC_BP_PROG = 4'hD,
    FBC_BP_ERASE = 4'hF,
    FBC_BP_EXIT = 4'hE,
    FBC_CFI = 4'hA
  } fbc_state_t;

  typedef enum logic [1:0] {
    FBC_OP_NONE = 2'h0,
    FBC_OP_PROG = 2'h1,
    FBC_OP_ERASE = 2'h2
  } fbc_op_t;
endpackage

// ---- hdl/fbc_strobe_capture.sv ----
// Write strobe capture: one write event per chip-select/write-strobe cycle.
// Assumes strobes sampled synchronously to sys_clk.
`timescale 1ns/1ps
`include "fbc_regs.svh"
module fbc_strobe_capture
  import fbc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Flash bus
  input wire logic chip_sel_n,
  input wire logic write_n,
  input wire logic [11:0] addr,
  input wire logic [31:0] data,
  // Captured write
  output logic wr_valid,
  output fbc_write_t wr
);
  logic active_q;
  logic [11:0] addr_q;
  wire logic both_low = !chip_sel_n && !write_n;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_q <= 1'b0;
    end else begin
      active_q <= both_low;
    end
  end

  // Address at the later falling edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q <= 12'h000;
    end else if (both_low && !active_q) begin
      addr_q <= addr;
    end
  end

  // Data at the earlier rising edge, which is also the event
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_valid <= 1'b0;
      wr <= '0;
    end else begin
      wr_valid <= active_q && !both_low;
      if (active_q && !both_low) begin
        wr.addr <= addr_q;
        wr.data <= data;
      end
    end
  end
endmodule

// ---- test/fbc_host.sv ----
// Host model: issues flash write cycles on chip select and write strobe.
// Assumes the interpreter samples the strobes on sys_clk rising edges.
`timescale 1ns/1ps
module fbc_host (
  // Clock
  input wire logic sys_clk,
  // Flash write bus
  output logic chip_sel_n,
  output logic write_n,
  output logic [11:0] addr,
  output logic [31:0] data
);
  initial begin
    chip_sel_n = 1'b1;
    write_n = 1'b1;
    addr = 12'h0;
    data = 32'h0;
  end
  // One write; address and data held one clock past release
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    chip_sel_n = 1'b0;
    write_n = 1'b0;
    addr = a;
    data = d;
    @(posedge sys_clk);
    #1;
    chip_sel_n = 1'b1;
    write_n = 1'b1;
    @(posedge sys_clk);
    #1;
    // Released bus must not look like a stale command
    addr = ~a;
    data = ~d;
  endtask
endmodule

// ---- test/fbc_cmd_fsm_asserts.sv ----
// Checker of the interpreter's status and array requests.
// Bound to fbc_cmd_fsm; sees its ports only.
`timescale 1ns/1ps
module fbc_cmd_fsm_asserts #(
  parameter int NUM_SECTORS = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Inputs
  input wire logic secured_sector_en,
  input wire logic [NUM_SECTORS-1:0] sector_protected,
  // Outputs
  input wire logic ready_busy_n,
  input wire logic data_poll_bit,
  input wire logic bypass_mode,
  input wire logic erase_suspended,
  input wire logic prog_we,
  input wire logic [NUM_SECTORS-1:0] erase_zero_we,
  input wire logic [NUM_SECTORS-1:0] erase_we
);
  property p_busy_prog;
    @(posedge sys_clk) disable iff (sys_rst) prog_we |=> !ready_busy_n;
  endproperty
  a_busy_prog: assert property (p_busy_prog) else $error("no busy after program");
  property p_erase_busy;
    @(posedge sys_clk) disable iff (sys_rst) (erase_we | erase_zero_we) != '0 |-> ##[0:1] !ready_busy_n;
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("erase pulse while idle");
  property p_protected;
    @(posedge sys_clk) disable iff (sys_rst) ((erase_we | erase_zero_we) & sector_protected) == '0;
  endproperty
  a_protected: assert property (p_protected) else $error("protected sector touched");
  property p_no_prog_busy;
    @(posedge sys_clk) disable iff (sys_rst)
      !ready_busy_n && $past(!ready_busy_n) && !erase_suspended |-> !prog_we;
  endproperty
  a_no_prog_busy: assert property (p_no_prog_busy) else $error("program while busy");
  property p_poll_idle;
    @(posedge sys_clk) disable iff (sys_rst) ready_busy_n [*2] |-> data_poll_bit;
  endproperty
  a_poll_idle: assert property (p_poll_idle) else $error("poll bit low while idle");
  property p_bypass_secured;
    @(posedge sys_clk) disable iff (sys_rst) $rose(bypass_mode) |-> !secured_sector_en;
  endproperty
  a_bypass_secured: assert property (p_bypass_secured) else $error("bypass entered");
  property p_prog_secured;
    @(posedge sys_clk) disable iff (sys_rst) prog_we && bypass_mode |-> !secured_sector_en;
  endproperty
  a_prog_secured: assert property (p_prog_secured) else $error("secured program");
  property p_reset_state;
    @(posedge sys_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> ready_busy_n && data_poll_bit && !bypass_mode;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
endmodule
bind fbc_cmd_fsm fbc_cmd_fsm_asserts #(.NUM_SECTORS(NUM_SECTORS)) u_asserts (.sys_clk, .sys_rst,
  .secured_sector_en, .sector_protected, .ready_busy_n, .data_poll_bit, .bypass_mode,
  .erase_suspended, .prog_we, .erase_zero_we, .erase_we);

// ---- test/fbc_cmd_fsm_tb.sv ----
// Testbench of the command interpreter, driven through the host model.
// Assumes short program and sector counts of 4 clocks.
`timescale 1ns/1ps
module fbc_cmd_fsm_tb;
  logic sys_clk, sys_rst, chip_sel_n, write_n, read_strobe, tg, pu;
  logic high_voltage_level, sector_protect_lock_bit, secured_sector_en;
  logic ready_busy_n, data_poll_bit, toggle_bit, bypass_mode, cfi_mode, erase_suspended;
  logic prog_we, prog_unprotected;
  logic [7:0] sector_protected, erase_zero_we, erase_we, er_acc, zr_acc, um;
  logic [11:0] addr, prog_addr, pa, a;
  logic [31:0] data, prog_data, pd, d, rd;
  int n_errors, checks, n_prog, n_tog, n;
  fbc_host u_host (.sys_clk, .chip_sel_n, .write_n, .addr, .data);
  fbc_cmd_fsm #(.PROG_CYCLES(4), .SECTOR_CYCLES(4)) u_dut (.sys_clk, .sys_rst, .chip_sel_n,
    .write_n, .addr, .data, .read_strobe, .high_voltage_level, .sector_protect_lock_bit,
    .secured_sector_en, .sector_protected, .ready_busy_n, .data_poll_bit, .toggle_bit,
    .bypass_mode, .cfi_mode, .erase_suspended, .prog_we, .prog_addr, .prog_data,
    .prog_unprotected, .erase_zero_we, .erase_we);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    #1 read_strobe = 1'($urandom);
  end
  // Records array requests seen at the ports
  always @(posedge sys_clk) begin
    if (prog_we === 1'b1) begin
      n_prog++;
      pa = prog_addr;
      pd = prog_data;
      pu = prog_unprotected;
    end
    er_acc |= erase_we;
    zr_acc |= erase_zero_we;
    if (toggle_bit !== tg) n_tog++;
    tg = toggle_bit;
  end
  function automatic logic exp_unprot(input logic hv, input logic lk);
    return hv & ~lk;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Busy rises only 3 clocks after the last strobe, so give it 4 first
  task automatic wait_ready;
    int i;
    repeat (4) @(posedge sys_clk);
    for (i = 0; i < 400 && ready_busy_n !== 1'b1; i++) @(posedge sys_clk);
    #1;
    if (i == 400) begin
      n_errors++;
      tally_and_finish;
    end
  endtask
  task automatic unl;
    u_host.wr(12'h555, 32'hAA);
    u_host.wr(12'h2AA, 32'h55);
  endtask
  task automatic erase6(input logic [31:0] last);
    unl();
    u_host.wr(12'h555, 32'h80);
    unl();
    u_host.wr(12'h555, last);
  endtask
  task automatic clr;
    er_acc = 8'h0;
    zr_acc = 8'h0;
    n_tog = 0;
    n = n_prog;
  endtask
  initial begin
    rd = $urandom(32'h8CA3);
    sys_rst = 1'b1;
    high_voltage_level = 1'b0;
    sector_protect_lock_bit = 1'b0;
    secured_sector_en = 1'b1;
    sector_protected = 8'h24;
    clr();
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    chk("idle", {ready_busy_n, data_poll_bit, bypass_mode}, 32'h6);
    unl();
    u_host.wr(12'h555, 32'h20);
    wait_ready();
    chk("bypass secured", bypass_mode, 32'h0);
    secured_sector_en = 1'b0;
    unl();
    u_host.wr(12'h555, 32'h20);
    wait_ready();
    chk("bypass", bypass_mode, 32'h1);
    $display("entry done");
    for (int k = 0; k < 6; k++) begin
      a = 12'($urandom);
      d = $urandom;
      // Refused data must not decode as a bypass command
      if (k > 3) d[7] = 1'b0;
      {sector_protect_lock_bit, high_voltage_level} = 2'(k);
      secured_sector_en = (k > 3);
      clr();
      u_host.wr(a, 32'hA0);
      u_host.wr(a, d);
      wait_ready();
      chk("prog count", n_prog - n, k > 3 ? 32'h0 : 32'h1);
      if (k < 4) begin
        chk("prog addr", pa, a);
        chk("prog data", pd, d);
        chk("unprotected", pu, exp_unprot(k[0], k[1]));
      end
    end
    secured_sector_en = 1'b0;
    clr();
    u_host.wr(12'h123, 32'h30);
    u_host.wr(12'h123, 32'h5A);
    wait_ready();
    chk("stray", {16'(n_prog - n), 16'(bypass_mode)}, 32'h1);
    u_host.wr(12'h055, 32'h98);
    wait_ready();
    chk("cfi", cfi_mode, 32'h1);
    u_host.wr(12'h000, 32'hF0);
    wait_ready();
    chk("cfi off", cfi_mode, 32'h0);
    $display("bypass program done");
    sector_protected = 8'($urandom);
    um = ~sector_protected;
    clr();
    u_host.wr(12'h000, 32'h80);
    u_host.wr(12'h000, 32'h10);
    u_host.wr(12'h000, 32'hB0);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("suspend", erase_suspended, 32'h0);
    wait_ready();
    chk("erased", er_acc, 32'(um));
    chk("zeroed", zr_acc, 32'(um));
    chk("toggled", n_tog > 0, 32'h1);
    u_host.wr(12'h000, 32'h90);
    u_host.wr(12'h7FF, 32'h00);
    wait_ready();
    chk("exit", bypass_mode, 32'h0);
    $display("bypass erase done");
    erase6(32'h11);
    wait_ready();
    chk("bad erase", ready_busy_n, 32'h1);
    clr();
    erase6(32'h10);
    unl();
    u_host.wr(12'h555, 32'hA0);
    u_host.wr(12'h100, 32'h0);
    chk("busy", {ready_busy_n, data_poll_bit}, 32'h0);
    sys_rst = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("abort", {ready_busy_n, 31'(n_prog - n)}, 32'h80000000);
    sys_rst = 1'b0;
    $display("chip erase done");
    tally_and_finish();
  end
endmodule
